// ---- lftlc_checker.sv ----
// Port-level assertions of the tag link controller
module lftlc_checker (
    input wire logic                         clk,
    input wire logic                         resetn,
    input wire lftlc_pkg::lftlc_apb_req_type apbReq,
    input wire lftlc_pkg::lftlc_apb_rsp_type apbRsp,
    input wire logic                         fieldClkPin,
    input wire logic                         gapPin,
    input wire logic                         modOut
);
    timeunit 1ns;
    timeprecision 1ps;
    import lftlc_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    logic acc;
    logic mapped;
    assign acc = apbReq.psel && apbReq.penable;
    assign mapped = apbReq.paddr inside {REG_STATUS, REG_CTRL, REG_MEM_ADDR, REG_MEM_DATA};
    sequence statusRead;
        acc && apbReq.paddr == REG_STATUS;
    endsequence
    a_ready_high: assert property (apbRsp.pready)
        else $error("pready low");
    a_err_in_access: assert property (apbRsp.pslverr |-> acc)
        else $error("pslverr outside access");
    a_err_unmapped: assert property (acc && !mapped |-> apbRsp.pslverr && apbRsp.prdata == '0)
        else $error("unmapped access not refused");
    a_mapped_no_err: assert property (acc && mapped |-> !apbRsp.pslverr)
        else $error("mapped access refused");
    a_gap_silences: assert property ($rose(gapPin) |-> ##[3:8] !modOut)
        else $error("modulation during gap");
    a_defeat_quiet: assert property (statusRead ##0 apbRsp.prdata[2:0] == 3'h7 |-> !modOut)
        else $error("modulation in defeat");
    a_idle_quiet: assert property (statusRead ##0 apbRsp.prdata[2:0] == 3'h0 |-> !apbRsp.prdata[21])
        else $error("modulation during init");
    a_count_bounded: assert property (statusRead |-> apbRsp.prdata[19:15] <= CNT_SAT)
        else $error("bit count past saturation");
endmodule // lftlc_checker

// ---- lftlc_pkg.sv ----
// Constants, types and bus carriers of the tag link controller
// Function
// - Transmit continuously after power-up, data or dummy
// - Regular read runs byte 0 to last, wraps
// - Last byte 15 for long ID, else 7
// - Regular read only with locked lock pattern
// - Every read entry starts with one zero
// - Direct access repeats addressed byte until command
// - Dummy is nine ones then 55/119 zeros
// - All-zero lock bits select the dummy pattern
// - Accept 18-33 as zero, 50-65 as one
// - Leave downlink after 64 idle field clocks
// - Execute only on matching count, else read
// - Start gap accepted once mode register loaded
// - Two-bit opcode 00 reloads configuration
// - Two-bit opcode 10 reads ID, even unlocked
// - Opcode 11 reads upper bytes or ID
// - Write byte: opcode, zero, data, address; sixteen
// - Direct access: opcode, zero, address; eight bits
// - Bits sent in order received and written
// - Validated write programs, then reads written byte
// - Erase, check zero, program, check written data
// - Manchester at 64 field clocks per bit
// - Configuration bit 0 selects ID length
// - Failed verification stops modulation until command
// - Write to locked memory enters byte read
package lftlc_pkg;

    localparam int          APB_AW        = 12;
    localparam int          APB_DW        = 32;

    localparam logic [11:0] REG_STATUS    = 12'h000;
    localparam logic [11:0] REG_CTRL      = 12'h004;
    localparam logic [11:0] REG_MEM_ADDR  = 12'h008;
    localparam logic [11:0] REG_MEM_DATA  = 12'h00C;
    localparam int          CTRL_FAIL_BIT = 0;

    localparam int          MEM_BYTES     = 17;
    localparam logic [4:0]  CFG_BYTE      = 5'h10;
    localparam logic [4:0]  FIRST_BYTE    = 5'h00;
    localparam logic [4:0]  UPPER_FIRST   = 5'h08;
    localparam logic [4:0]  LAST_SHORT    = 5'h07;
    localparam logic [4:0]  LAST_LONG     = 5'h0F;
    localparam logic [7:0]  CFG_DEFAULT   = 8'h06;
    localparam int          LOCK_HI       = 7;
    localparam int          LOCK_LO       = 3;
    localparam int          IDLEN_BIT     = 0;
    localparam logic [4:0]  LOCK_LOCKED   = 5'h0D;
    localparam logic [4:0]  LOCK_OPEN     = 5'h00;

    localparam logic [5:0]  BIT_LAST_TICK = 6'h3F;
    localparam logic [5:0]  HALF_BIT      = 6'h20;
    localparam logic [2:0]  LAST_BIT_POS  = 3'h7;
    localparam logic [6:0]  HEADER_ONES   = 7'h09;
    localparam logic [6:0]  DUMMY_LAST_S  = 7'h3F;
    localparam logic [6:0]  DUMMY_LAST_L  = 7'h7F;

    localparam logic [6:0]  ZERO_MIN      = 7'h12;
    localparam logic [6:0]  ZERO_MAX      = 7'h21;
    localparam logic [6:0]  ONE_MIN       = 7'h32;
    localparam logic [6:0]  ONE_MAX       = 7'h41;
    localparam logic [6:0]  IDLE_MAX      = 7'h40;
    localparam logic [6:0]  SPACE_SAT     = 7'h7F;
    localparam logic [6:0]  INIT_LAST     = 7'h61;

    localparam logic [4:0]  CNT_SHORT     = 5'h02;
    localparam logic [4:0]  CNT_DIRECT    = 5'h08;
    localparam logic [4:0]  CNT_WRITE     = 5'h10;
    localparam logic [4:0]  CNT_SAT       = 5'h11;
    localparam logic [1:0]  OP_RESET      = 2'h0;
    localparam logic [1:0]  OP_READ       = 2'h2;
    localparam logic [1:0]  OP_UPPER      = 2'h3;

    localparam int          PROG_TIME_NS  = 5600000;
    localparam int          CLK_PERIOD_NS = 8;
    localparam int          PROG_CYCLES   = PROG_TIME_NS / CLK_PERIOD_NS;
    localparam int          PROG_STEPS    = 4;

    typedef struct packed {
        logic [APB_AW-1:0] paddr;
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [APB_DW-1:0] pwdata;
    } lftlc_apb_req_type;

    typedef struct packed {
        logic [APB_DW-1:0] prdata;
        logic              pready;
        logic              pslverr;
    } lftlc_apb_rsp_type;

    typedef enum logic [2:0] {
        ST_INIT,
        ST_READ,
        ST_DOWNLINK,
        ST_ERASE,
        ST_ERASE_CHK,
        ST_PROG,
        ST_PROG_CHK,
        ST_DEFEAT
    } lftlc_state_type;

endpackage

// ---- lftlc_reader_model.sv ----
// Behavioural base-station reader: free carrier clock and gap keying
module lftlc_reader_model (
    input wire logic clk,
    output logic     fieldClkPin,
    output logic     gapPin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] div_q;
    initial begin
        fieldClkPin = 1'b0;
        gapPin = 1'b0;
        div_q = '0;
    end
    // Carrier runs free; 10 clk per field clock keeps sync margin
    always @(posedge clk) begin
        div_q <= (div_q == 3'h4) ? 3'h0 : div_q + 3'h1;
        if (div_q == 3'h4) fieldClkPin <= ~fieldClkPin;
    end
    // MSB first; final gap closes the last spacing
    task automatic send(input logic [15:0] b, input int n, input int bad);
        int s;
        for (int i = 0; i <= n; i++) begin
            s = (i == n) ? 10 : (i == bad) ? 40 : b[n-1-i] ? 58 : 25;
            gapPin <= 1'b1;
            repeat (i == 0 ? 15 : 10) @(posedge fieldClkPin);
            gapPin <= 1'b0;
            repeat (s - (i == 0 ? 15 : 10)) @(posedge fieldClkPin);
        end
    endtask
endmodule // lftlc_reader_model

// ---- lftlc_tag_link_controller.sv ----
// Tag protocol engine: uplink serialiser, downlink decoder, programmer, APB
module lftlc_tag_link_controller #(
    parameter int PROG_STEP_CYCLES = lftlc_pkg::PROG_CYCLES / lftlc_pkg::PROG_STEPS
) (
    input  wire logic                        clk,
    input  wire logic                        resetn,
    input  wire lftlc_pkg::lftlc_apb_req_type apbReq,
    output lftlc_pkg::lftlc_apb_rsp_type      apbRsp,
    input  wire logic                        fieldClkPin,
    input  wire logic                        gapPin,
    output logic                             modOut
);
    import lftlc_pkg::*;

    // Synchronisers and edge detectors
    logic            fieldS1_q;
    logic            fieldS2_q;
    logic            fieldPrev_q;
    logic            gapS1_q;
    logic            gapS2_q;
    logic            gapPrev_q;
    logic            fieldTick;
    logic            gapStart;

    // Memory and configuration
    logic [7:0]      mem_q [MEM_BYTES];
    logic [7:0]      memCfg;
    logic [7:0]      cfg_q;
    logic            locked;
    logic            lockOpen;
    logic [4:0]      lastByte;

    // Control
    lftlc_state_type st_q;
    logic [6:0]      initCnt_q;
    logic [19:0]     stepCnt_q;
    logic            stepEnd;
    logic [4:0]      rdFirst_q;
    logic [4:0]      rdLast_q;
    logic            srcDummy_q;
    logic            startRead_q;
    logic [4:0]      wrAddr_q;
    logic [7:0]      wrData_q;
    logic            eraseStb_q;
    logic            progStb_q;

    // Downlink
    logic [6:0]      spaceCnt_q;
    logic [15:0]     shift_q;
    logic [4:0]      bitCnt_q;
    logic            dlErr_q;
    logic            dlDone;
    logic            spaceZero;
    logic            spaceOne;

    // Uplink
    logic [5:0]      halfCnt_q;
    logic [4:0]      byteIdx_q;
    logic [2:0]      bitIdx_q;
    logic [6:0]      dumCnt_q;
    logic            leadZero_q;
    logic            curBit;

    // Command decode results
    logic            goRead;
    logic [4:0]      goFirst;
    logic [4:0]      goLast;
    logic            goDummy;
    logic            goInit;
    logic            goProg;
    logic [4:0]      cmdAddr;
    logic [7:0]      cmdData;
    logic            addrOk;

    // Bus side
    logic            ctrlFail_q;
    logic [4:0]      memAddr_q;
    logic            apbWr;
    logic            apbAcc;
    logic            apbHit;
    logic [31:0]     prdata_q;
    logic            pslverr_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fieldS1_q   <= 1'b0;
            fieldS2_q   <= 1'b0;
            fieldPrev_q <= 1'b0;
            gapS1_q     <= 1'b0;
            gapS2_q     <= 1'b0;
            gapPrev_q   <= 1'b0;
        end else begin
            fieldS1_q   <= fieldClkPin;
            fieldS2_q   <= fieldS1_q;
            fieldPrev_q <= fieldS2_q;
            gapS1_q     <= gapPin;
            gapS2_q     <= gapS1_q;
            gapPrev_q   <= gapS2_q;
        end
    end

    // Field clock is slow against clk, so one enable per carrier period
    assign fieldTick = fieldS2_q & ~fieldPrev_q;
    assign gapStart  = gapS2_q & ~gapPrev_q;

    assign memCfg   = mem_q[CFG_BYTE];
    assign locked   = memCfg[LOCK_HI:LOCK_LO] == LOCK_LOCKED;
    assign lockOpen = memCfg[LOCK_HI:LOCK_LO] == LOCK_OPEN;
    assign lastByte = memCfg[IDLEN_BIT] ? LAST_LONG : LAST_SHORT;

    // Gap spacing counter, cleared at every gap start
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            spaceCnt_q <= 7'h00;
        end else if (gapStart) begin
            spaceCnt_q <= 7'h00;
        end else if (fieldTick && spaceCnt_q != SPACE_SAT) begin
            spaceCnt_q <= spaceCnt_q + 7'h01;
        end
    end

    assign spaceZero = spaceCnt_q >= ZERO_MIN && spaceCnt_q <= ZERO_MAX;
    assign spaceOne  = spaceCnt_q >= ONE_MIN && spaceCnt_q <= ONE_MAX;
    assign dlDone    = st_q == ST_DOWNLINK && spaceCnt_q > IDLE_MAX;

    // Downlink bit capture; first bit lands in the top of the word
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shift_q  <= 16'h0000;
            bitCnt_q <= 5'h00;
            dlErr_q  <= 1'b0;
        end else if (gapStart && st_q != ST_DOWNLINK) begin
            shift_q  <= 16'h0000;
            bitCnt_q <= 5'h00;
            dlErr_q  <= 1'b0;
        end else if (gapStart) begin
            shift_q <= {shift_q[14:0], spaceOne};
            if (bitCnt_q != CNT_SAT) begin
                bitCnt_q <= bitCnt_q + 5'h01;
            end
            if (!spaceZero && !spaceOne) begin
                dlErr_q <= 1'b1;
            end
        end
    end

    // Command decode
    always_comb begin
        goRead  = 1'b0;
        goFirst = FIRST_BYTE;
        goLast  = lastByte;
        goDummy = !locked;  // Undefined patterns fall back to the power-up source, dummy unless locked
        goInit  = 1'b0;
        goProg  = 1'b0;
        cmdAddr = shift_q[4:0];
        cmdData = shift_q[12:5];
        addrOk  = shift_q[4:0] <= CFG_BYTE;
        if (dlErr_q) begin
            goRead = 1'b1;
        end else if (bitCnt_q == CNT_SHORT) begin
            case (shift_q[1:0])
                OP_RESET: goInit = 1'b1;
                OP_READ: begin
                    goRead  = 1'b1;
                    goDummy = 1'b0;
                end
                OP_UPPER: begin
                    goRead  = 1'b1;
                    goDummy = 1'b0;
                    if (!memCfg[IDLEN_BIT]) begin
                        goFirst = UPPER_FIRST;
                        goLast  = LAST_LONG;
                    end
                end
                default: goRead = 1'b1;
            endcase
        end else if (bitCnt_q == CNT_DIRECT && shift_q[7:5] == {OP_READ, 1'b0} && addrOk) begin
            goRead  = 1'b1;
            goDummy = 1'b0;
            goFirst = cmdAddr;
            goLast  = cmdAddr;
        end else if (bitCnt_q == CNT_WRITE && shift_q[15:13] == {OP_READ, 1'b0} && addrOk) begin
            if (!lockOpen) begin
                goRead  = 1'b1;
                goDummy = 1'b0;
                goFirst = cmdAddr;
                goLast  = cmdAddr;
            end else begin
                goProg = 1'b1;
            end
        end else begin
            goRead = 1'b1;
        end
    end

    assign stepEnd = stepCnt_q == 20'(PROG_STEP_CYCLES - 1);

    // Main sequencer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q        <= ST_INIT;
            cfg_q       <= CFG_DEFAULT;
            initCnt_q   <= 7'h00;
            stepCnt_q   <= 20'h00000;
            rdFirst_q   <= FIRST_BYTE;
            rdLast_q    <= LAST_SHORT;
            srcDummy_q  <= 1'b1;
            startRead_q <= 1'b0;
            wrAddr_q    <= 5'h00;
            wrData_q    <= 8'h00;
            eraseStb_q  <= 1'b0;
            progStb_q   <= 1'b0;
        end else begin
            startRead_q <= 1'b0;
            eraseStb_q  <= 1'b0;
            progStb_q   <= 1'b0;
            case (st_q)
                ST_INIT: begin
                    if (fieldTick) begin
                        initCnt_q <= initCnt_q + 7'h01;
                        if (initCnt_q == INIT_LAST) begin
                            cfg_q       <= memCfg;
                            st_q        <= ST_READ;
                            rdFirst_q   <= FIRST_BYTE;
                            rdLast_q    <= lastByte;
                            srcDummy_q  <= !locked;
                            startRead_q <= 1'b1;
                        end
                    end
                end
                ST_READ, ST_DEFEAT: begin
                    if (st_q == ST_READ) begin
                        cfg_q <= memCfg;
                    end
                    if (gapStart) begin
                        st_q <= ST_DOWNLINK;
                    end
                end
                ST_DOWNLINK: begin
                    if (dlDone) begin
                        if (goInit) begin
                            st_q      <= ST_INIT;
                            initCnt_q <= 7'h00;
                        end else if (goProg) begin
                            st_q      <= ST_ERASE;
                            stepCnt_q <= 20'h00000;
                            wrAddr_q  <= cmdAddr;
                            wrData_q  <= cmdData;
                        end else begin
                            st_q        <= ST_READ;
                            rdFirst_q   <= goFirst;
                            rdLast_q    <= goLast;
                            srcDummy_q  <= goDummy;
                            startRead_q <= goRead;
                        end
                    end
                end
                ST_ERASE, ST_ERASE_CHK, ST_PROG, ST_PROG_CHK: begin
                    stepCnt_q <= stepCnt_q + 20'h00001;
                    if (stepEnd) begin
                        stepCnt_q <= 20'h00000;
                        case (st_q)
                            ST_ERASE: begin
                                eraseStb_q <= 1'b1;
                                st_q       <= ST_ERASE_CHK;
                            end
                            ST_ERASE_CHK: begin
                                if (mem_q[wrAddr_q] != 8'h00 || ctrlFail_q) begin
                                    st_q <= ST_DEFEAT;
                                end else begin
                                    st_q <= ST_PROG;
                                end
                            end
                            ST_PROG: begin
                                progStb_q <= 1'b1;
                                st_q      <= ST_PROG_CHK;
                            end
                            default: begin
                                if (mem_q[wrAddr_q] != wrData_q || ctrlFail_q) begin
                                    st_q <= ST_DEFEAT;
                                end else begin
                                    st_q        <= ST_READ;
                                    rdFirst_q   <= wrAddr_q;
                                    rdLast_q    <= wrAddr_q;
                                    srcDummy_q  <= 1'b0;
                                    startRead_q <= 1'b1;
                                end
                            end
                        endcase
                    end
                end
                default: st_q <= ST_INIT;
            endcase
        end
    end

    // Nonvolatile array; backdoor port loads it for bench and production
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < MEM_BYTES; i++) begin
                mem_q[i] <= (i == int'(CFG_BYTE)) ? CFG_DEFAULT : 8'h00;
            end
        end else if (eraseStb_q) begin
            mem_q[wrAddr_q] <= 8'h00;
        end else if (progStb_q) begin
            mem_q[wrAddr_q] <= wrData_q;
        end else if (apbWr && apbReq.paddr == REG_MEM_DATA && memAddr_q <= CFG_BYTE) begin
            mem_q[memAddr_q] <= apbReq.pwdata[7:0];
        end
    end

    // Bit source: leading zero, dummy header, or memory MSB first
    always_comb begin
        if (leadZero_q) begin
            curBit = 1'b0;
        end else if (srcDummy_q) begin
            curBit = dumCnt_q < HEADER_ONES;
        end else begin
            curBit = mem_q[byteIdx_q][LAST_BIT_POS - bitIdx_q];
        end
    end

    // Uplink pointers, advanced once per 64 field clocks
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            halfCnt_q  <= 6'h00;
            byteIdx_q  <= FIRST_BYTE;
            bitIdx_q   <= 3'h0;
            dumCnt_q   <= 7'h00;
            leadZero_q <= 1'b1;
        end else if (startRead_q) begin
            halfCnt_q  <= 6'h00;
            byteIdx_q  <= rdFirst_q;
            bitIdx_q   <= 3'h0;
            dumCnt_q   <= 7'h00;
            leadZero_q <= 1'b1;
        end else if (st_q == ST_READ && fieldTick) begin
            halfCnt_q <= halfCnt_q + 6'h01;
            if (halfCnt_q == BIT_LAST_TICK) begin
                if (leadZero_q) begin
                    leadZero_q <= 1'b0;
                end else if (srcDummy_q) begin
                    if (dumCnt_q == (cfg_q[IDLEN_BIT] ? DUMMY_LAST_L : DUMMY_LAST_S)) begin
                        dumCnt_q <= 7'h00;
                    end else begin
                        dumCnt_q <= dumCnt_q + 7'h01;
                    end
                end else begin
                    bitIdx_q <= bitIdx_q + 3'h1;
                    if (bitIdx_q == LAST_BIT_POS) begin
                        if (byteIdx_q >= rdLast_q) begin
                            byteIdx_q <= rdFirst_q;
                        end else begin
                            byteIdx_q <= byteIdx_q + 5'h01;
                        end
                    end
                end
            end
        end
    end

    // Manchester: low then high half is a one, damping off outside reads
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            modOut <= 1'b0;
        end else if (st_q == ST_READ) begin
            modOut <= (halfCnt_q < HALF_BIT) ? ~curBit : curBit;
        end else begin
            modOut <= 1'b0;
        end
    end

    // APB slave, zero wait states
    assign apbAcc = apbReq.psel & apbReq.penable;
    assign apbWr  = apbAcc & apbReq.pwrite & apbHit;
    assign apbHit = apbReq.paddr == REG_STATUS || apbReq.paddr == REG_CTRL
                 || apbReq.paddr == REG_MEM_ADDR || apbReq.paddr == REG_MEM_DATA;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrlFail_q <= 1'b0;
            memAddr_q  <= 5'h00;
        end else if (apbWr) begin
            if (apbReq.paddr == REG_CTRL) begin
                ctrlFail_q <= apbReq.pwdata[CTRL_FAIL_BIT];
            end
            if (apbReq.paddr == REG_MEM_ADDR) begin
                memAddr_q <= apbReq.pwdata[4:0];
            end
        end
    end

    // Read data registered in setup so it is stable through the access
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prdata_q  <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else if (apbReq.psel && !apbReq.penable) begin
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
            case (apbReq.paddr)
                REG_STATUS: prdata_q <= {10'h0, modOut, dlErr_q, bitCnt_q,
                                         cfg_q, 4'h0, st_q};
                REG_CTRL: prdata_q <= {31'h0, ctrlFail_q};
                REG_MEM_ADDR: prdata_q <= {27'h0, memAddr_q};
                REG_MEM_DATA: prdata_q <= (memAddr_q <= CFG_BYTE)
                                          ? {24'h000000, mem_q[memAddr_q]} : 32'h00000000;
                default: pslverr_q <= 1'b1;
            endcase
        end
    end

    assign apbRsp.prdata  = prdata_q;
    assign apbRsp.pready  = 1'b1;
    assign apbRsp.pslverr = pslverr_q & apbAcc;

endmodule // lftlc_tag_link_controller

// ---- lftlc_tag_link_controller_test.sv ----
// Self-checking bench of the tag link controller
module lftlc_tag_link_controller_test;
    timeunit 1ns;
    timeprecision 1ps;
    import lftlc_pkg::*;
    logic clk;
    logic resetn;
    lftlc_apb_req_type req;
    lftlc_apb_rsp_type rsp;
    logic fieldClkPin;
    logic gapPin;
    logic modOut;
    logic err;
    logic [31:0] r;
    logic [7:0] v;
    logic expQ[$];
    int mem[17];
    int num_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    lftlc_tag_link_controller #(.PROG_STEP_CYCLES(8)) i_lftlc_tag_link_controller (
        .clk(clk), .resetn(resetn), .apbReq(req), .apbRsp(rsp),
        .fieldClkPin(fieldClkPin), .gapPin(gapPin), .modOut(modOut));
    lftlc_reader_model i_lftlc_reader_model (
        .clk(clk), .fieldClkPin(fieldClkPin), .gapPin(gapPin));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        req <= '{a, 1'b1, 1'b0, w, d};
        @(posedge clk);
        req.penable <= 1'b1;
        do @(posedge clk); while (rsp.pready !== 1'b1);
        r = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
        @(posedge clk);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge fieldClkPin);
    endtask
    task automatic pushByte(input logic [7:0] b);
        for (int k = 7; k >= 0; k--) expQ.push_back(b[k]);
    endtask
    // Syncs on first rising edge, then samples mid of each half bit
    task automatic rx(input int off);
        wait (modOut === 1'b0);
        wait (modOut === 1'b1);
        tick(off);
        foreach (expQ[i]) begin
            chk(32'(modOut), 32'(expQ[i]), "second half");
            tick(32);
            if (i + 1 < expQ.size()) chk(32'(modOut), 32'(!expQ[i+1]), "first half");
            tick(32);
        end
        $display("stream test done at %0t", $time);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            num_errors++;
            $display("[FAIL] %0t timeout", $time);
            conclude();
        end
    end
    initial begin
        req = '0;
        resetn = 1'b0;
        void'($urandom(32'hE14B));
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        // Leading zero, then nine header ones and zeros
        for (int i = 0; i < 17; i++) expQ.push_back(i > 0 && i < 10);
        rx(48);
        apb(1'b0, REG_STATUS, 32'h0);
        chk(32'(r[14:7]), 32'(CFG_DEFAULT), "config");
        apb(1'b0, 12'h010, 32'h0);
        chk(32'(err), 32'h1, "unmapped");
        v = 8'($urandom);
        mem[5] = v;
        apb(1'b1, REG_MEM_ADDR, 32'h5);
        apb(1'b1, REG_MEM_DATA, 32'(v));
        i_lftlc_reader_model.send(16'h0085, 8, -1);
        expQ = {1'b0};
        pushByte(8'(mem[5]));
        pushByte(8'(mem[5]));
        rx(48);
        v = 8'($urandom);
        mem[3] = v;
        i_lftlc_reader_model.send({2'b10, 1'b0, v, 5'h03}, 16, -1);
        expQ = {1'b0};
        pushByte(v);
        rx(48);
        apb(1'b1, REG_MEM_ADDR, 32'h3);
        apb(1'b0, REG_MEM_DATA, 32'h0);
        chk(r, 32'(mem[3]), "programmed byte");
        i_lftlc_reader_model.send(16'h0085, 8, 3);
        tick(80);
        apb(1'b0, REG_STATUS, 32'h0);
        chk(32'(r[2:0]), 32'h1, "abandoned command");
        i_lftlc_reader_model.send(16'h0000, 2, -1);
        tick(60);
        apb(1'b0, REG_STATUS, 32'h0);
        chk(32'(r[2:0]), 32'h0, "reset command");
        tick(100);
        apb(1'b1, REG_CTRL, 32'h1);
        i_lftlc_reader_model.send({2'b10, 1'b0, 8'hA5, 5'h02}, 16, -1);
        tick(80);
        apb(1'b0, REG_STATUS, 32'h0);
        chk(32'(r[2:0]), 32'h7, "defeat state");
        chk(32'(modOut), 32'h0, "defeat quiet");
        conclude();
    end
endmodule // lftlc_tag_link_controller_test
bind lftlc_tag_link_controller lftlc_checker i_lftlc_checker (
    .clk(clk), .resetn(resetn), .apbReq(apbReq), .apbRsp(apbRsp),
    .fieldClkPin(fieldClkPin), .gapPin(gapPin), .modOut(modOut));
